// ===== rtl/gpx_defs.svh
// Constants for the bank E to H general-purpose pin block
`ifndef GPX_DEFS_SVH
`define GPX_DEFS_SVH
// Register indices; byte address is index times four
`define GPX_IDX_E_LATCH 6'h08
`define GPX_IDX_F_LATCH 6'h09
`define GPX_IDX_G_LATCH 6'h0A
`define GPX_IDX_H_LATCH 6'h0B
`define GPX_IDX_E_DIR 6'h0C
`define GPX_IDX_F_DIR 6'h0D
`define GPX_IDX_G_DIR 6'h0E
`define GPX_IDX_H_DIR 6'h0F
`define GPX_E_W 8
`define GPX_F_W 6
`define GPX_G_W 4
`define GPX_H_W 4
`define GPX_DIR_RST 8'h00
`define GPX_RESP_OKAY 2'h0
`define GPX_RESP_SLVERR 2'h2
`define GPX_BIT_SCI_TX 2
`define GPX_BIT_SCI_RX 1
`define GPX_BIT_SS 0
`endif

// ===== rtl/gpx_pkg.sv
// Types shared by the pin block
package gpx_pkg;
  typedef enum logic [1:0] {
    GPX_WR_IDLE = 2'b00,
    GPX_WR_RESP = 2'b01
  } gpx_wr_state_t;
endpackage

// ===== rtl/gpx_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module gpx_sync #(
  parameter int W = 8
) (
  // Clock
  input wire logic aclk,
  input wire logic ce,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  // No reset: pin levels are unknown until sampled anyway
  always_ff @(posedge aclk) begin
    if (ce) begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
  assign q = q_ff;
endmodule

// ===== rtl/gpx_bank.sv
// One pin bank: latch, direction, drive selection and read mux
`timescale 1ns/1ps
module gpx_bank #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Register writes
  input wire logic latch_we,
  input wire logic dir_we,
  input wire logic [W-1:0] wdata,
  // Peripheral ownership per pin
  input wire logic [W-1:0] per_own,
  input wire logic [W-1:0] per_drive,
  input wire logic [W-1:0] per_out,
  // Pins, already synchronised
  input wire logic [W-1:0] pin_sync,
  output logic [W-1:0] nxt_pin_out,
  output logic [W-1:0] nxt_pin_oe_n,
  // Read side
  output logic [W-1:0] rd_data,
  output logic [W-1:0] dir_q
);
  logic [W-1:0] latch_ff;
  logic [W-1:0] dir_ff;
  logic [W-1:0] drive_en;
  // Latch has no reset so its contents survive a reset
  always_ff @(posedge aclk) begin
    if (ce && latch_we) begin
      latch_ff <= wdata;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_ff <= '0;
    end else if (ce && dir_we) begin
      dir_ff <= wdata;
    end
  end
  assign drive_en = (per_own & per_drive) | (~per_own & dir_ff);
  assign nxt_pin_out = (per_own & per_out) | (~per_own & latch_ff);
  assign nxt_pin_oe_n = ~drive_en;
  assign rd_data = (dir_ff & latch_ff) | (~dir_ff & pin_sync);
  assign dir_q = dir_ff;
endmodule

// ===== rtl/gpx_top.sv
// General-purpose pin banks E to H with an AXI4-Lite register slave
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "gpx_defs.svh"
module gpx_top
  import gpx_pkg::*;
(
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Bank E pins
  input wire logic [7:0] bank_e_bit_in,
  output logic [7:0] bank_e_bit_out,
  output logic [7:0] bank_e_bit_oe_n,
  // Bank F pins
  input wire logic [5:0] bank_f_bit_in,
  output logic [5:0] bank_f_bit_out,
  output logic [5:0] bank_f_bit_oe_n,
  // Bank G pins
  input wire logic [3:0] bank_g_bit_in,
  output logic [3:0] bank_g_bit_out,
  output logic [3:0] bank_g_bit_oe_n,
  // Bank H pins
  input wire logic [3:0] bank_h_bit_in,
  output logic [3:0] bank_h_bit_out,
  output logic [3:0] bank_h_bit_oe_n,
  // Timer ownership of bank E pins 7..3
  input wire logic [4:0] timer_own,
  input wire logic [4:0] timer_drive,
  input wire logic [4:0] timer_out,
  // Serial interface
  input wire logic serial_interface_enable,
  input wire logic sci_txd,
  // SPI
  input wire logic spi_enable_bit,
  input wire logic spi_master_select,
  input wire logic [3:0] spi_drive,
  input wire logic [3:0] spi_out,
  // Synchronised pin levels for the peripherals
  output logic [7:0] bank_e_pin_level,
  output logic [5:0] bank_f_pin_level
);

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  gpx_wr_state_t wr_state_ff;
  gpx_wr_state_t nxt_wr_state;
  logic aw_got_ff;
  logic w_got_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic aw_hs;
  logic w_hs;
  logic wr_fire;
  logic [5:0] wr_idx;
  logic wr_hit;
  logic wr_lane0;

  assign aw_hs = s_axi_awvalid && awready_ff;
  assign w_hs = s_axi_wvalid && wready_ff;
  // Fire once both halves are held; address and data may arrive in either order
  assign wr_fire = ce && (wr_state_ff == GPX_WR_IDLE) && aw_got_ff && w_got_ff;
  assign wr_idx = aw_addr_ff[7:2];
  assign wr_hit = (wr_idx >= `GPX_IDX_E_LATCH) && (wr_idx <= `GPX_IDX_H_DIR) && (aw_addr_ff[1:0] == 2'h0);
  // Every register sits in byte lane 0
  assign wr_lane0 = w_strb_ff[0];

  always_comb begin
    nxt_wr_state = wr_state_ff;
    case (wr_state_ff)
      GPX_WR_IDLE: begin
        if (wr_fire) begin
          nxt_wr_state = GPX_WR_RESP;
        end
      end
      GPX_WR_RESP: begin
        if (ce && s_axi_bready) begin
          nxt_wr_state = GPX_WR_IDLE;
        end
      end
      default: begin
        nxt_wr_state = GPX_WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_ff <= GPX_WR_IDLE;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h00000000;
      w_strb_ff <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `GPX_RESP_OKAY;
    end else if (ce) begin
      wr_state_ff <= nxt_wr_state;
      awready_ff <= !aw_got_ff && !aw_hs && (wr_state_ff == GPX_WR_IDLE);
      wready_ff <= !w_got_ff && !w_hs && (wr_state_ff == GPX_WR_IDLE);
      if (aw_hs) begin
        aw_got_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_got_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? `GPX_RESP_OKAY : `GPX_RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // Per-register write enables
  logic we_ok;
  logic [7:0] wbyte;
  assign we_ok = wr_fire && wr_hit && wr_lane0;
  assign wbyte = w_data_ff[7:0];

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [7:0] e_sync;
  logic [5:0] f_sync;
  logic [3:0] g_sync;
  logic [3:0] h_sync;
  gpx_sync #(.W(`GPX_E_W)) u_sync_e (.aclk(aclk), .ce(ce), .d(bank_e_bit_in), .q(e_sync));
  gpx_sync #(.W(`GPX_F_W)) u_sync_f (.aclk(aclk), .ce(ce), .d(bank_f_bit_in), .q(f_sync));
  gpx_sync #(.W(`GPX_G_W)) u_sync_g (.aclk(aclk), .ce(ce), .d(bank_g_bit_in), .q(g_sync));
  gpx_sync #(.W(`GPX_H_W)) u_sync_h (.aclk(aclk), .ce(ce), .d(bank_h_bit_in), .q(h_sync));

  // ************************************************************
  // Peripheral pin ownership
  // ************************************************************
  logic [7:0] e_own;
  logic [7:0] e_pdrv;
  logic [7:0] e_pout;
  logic [5:0] f_own;
  logic [5:0] f_pdrv;
  logic [5:0] f_pout;
  logic ss_owned;
  // Receive pin is input only while the serial interface holds it
  assign e_own = {timer_own, serial_interface_enable, serial_interface_enable, 1'b0};
  assign e_pdrv = {timer_drive, 1'b1, 1'b0, 1'b0};
  assign e_pout = {timer_out, sci_txd, 1'b0, 1'b0};
  // Slave select is free only when the SPI is off; in master mode it is still held, undriven
  assign ss_owned = spi_enable_bit && !spi_master_select;
  assign f_own = {2'b00, {3{spi_enable_bit}}, ss_owned};
  // Bit 0 in master mode: still not steered by its direction bit while enabled
  assign f_pdrv = {2'b00, spi_drive[3:1], 1'b0};
  assign f_pout = {2'b00, spi_out[3:0]};
  logic [5:0] f_own_drv;
  assign f_own_drv = f_own | {5'b00000, spi_enable_bit};

  // ************************************************************
  // Banks
  // ************************************************************
  logic [7:0] e_rd;
  logic [5:0] f_rd;
  logic [3:0] g_rd;
  logic [3:0] h_rd;
  logic [7:0] e_dir;
  logic [5:0] f_dir;
  logic [3:0] g_dir;
  logic [3:0] h_dir;
  logic [7:0] e_nout;
  logic [7:0] e_noe;
  logic [5:0] f_nout;
  logic [5:0] f_noe;
  logic [3:0] g_nout;
  logic [3:0] g_noe;
  logic [3:0] h_nout;
  logic [3:0] h_noe;

  gpx_bank #(.W(`GPX_E_W)) u_bank_e (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .latch_we(we_ok && (wr_idx == `GPX_IDX_E_LATCH)),
    .dir_we(we_ok && (wr_idx == `GPX_IDX_E_DIR)),
    .wdata(wbyte),
    .per_own(e_own), .per_drive(e_pdrv), .per_out(e_pout),
    .pin_sync(e_sync), .nxt_pin_out(e_nout), .nxt_pin_oe_n(e_noe),
    .rd_data(e_rd), .dir_q(e_dir)
  );
  gpx_bank #(.W(`GPX_F_W)) u_bank_f (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .latch_we(we_ok && (wr_idx == `GPX_IDX_F_LATCH)),
    .dir_we(we_ok && (wr_idx == `GPX_IDX_F_DIR)),
    .wdata(wbyte[5:0]),
    .per_own(f_own_drv), .per_drive(f_pdrv), .per_out(f_pout),
    .pin_sync(f_sync), .nxt_pin_out(f_nout), .nxt_pin_oe_n(f_noe),
    .rd_data(f_rd), .dir_q(f_dir)
  );
  gpx_bank #(.W(`GPX_G_W)) u_bank_g (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .latch_we(we_ok && (wr_idx == `GPX_IDX_G_LATCH)),
    .dir_we(we_ok && (wr_idx == `GPX_IDX_G_DIR)),
    .wdata(wbyte[3:0]),
    .per_own(4'h0), .per_drive(4'h0), .per_out(4'h0),
    .pin_sync(g_sync), .nxt_pin_out(g_nout), .nxt_pin_oe_n(g_noe),
    .rd_data(g_rd), .dir_q(g_dir)
  );
  gpx_bank #(.W(`GPX_H_W)) u_bank_h (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .latch_we(we_ok && (wr_idx == `GPX_IDX_H_LATCH)),
    .dir_we(we_ok && (wr_idx == `GPX_IDX_H_DIR)),
    .wdata(wbyte[3:0]),
    .per_own(4'h0), .per_drive(4'h0), .per_out(4'h0),
    .pin_sync(h_sync), .nxt_pin_out(h_nout), .nxt_pin_oe_n(h_noe),
    .rd_data(h_rd), .dir_q(h_dir)
  );

  // ************************************************************
  // Registered pin outputs
  // ************************************************************
  // One flop after the mux keeps the pads glitch free; pads float during reset
  logic [7:0] e_out_ff;
  logic [7:0] e_oe_n_ff;
  logic [5:0] f_out_ff;
  logic [5:0] f_oe_n_ff;
  logic [3:0] g_out_ff;
  logic [3:0] g_oe_n_ff;
  logic [3:0] h_out_ff;
  logic [3:0] h_oe_n_ff;
  logic [7:0] e_lvl_ff;
  logic [5:0] f_lvl_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      e_out_ff <= 8'h00;
      e_oe_n_ff <= 8'hFF;
      f_out_ff <= 6'h00;
      f_oe_n_ff <= 6'h3F;
      g_out_ff <= 4'h0;
      g_oe_n_ff <= 4'hF;
      h_out_ff <= 4'h0;
      h_oe_n_ff <= 4'hF;
      e_lvl_ff <= 8'h00;
      f_lvl_ff <= 6'h00;
    end else if (ce) begin
      e_out_ff <= e_nout;
      e_oe_n_ff <= e_noe;
      f_out_ff <= f_nout;
      f_oe_n_ff <= f_noe;
      g_out_ff <= g_nout;
      g_oe_n_ff <= g_noe;
      h_out_ff <= h_nout;
      h_oe_n_ff <= h_noe;
      e_lvl_ff <= e_sync;
      f_lvl_ff <= f_sync;
    end
  end
  assign bank_e_bit_out = e_out_ff;
  assign bank_e_bit_oe_n = e_oe_n_ff;
  assign bank_f_bit_out = f_out_ff;
  assign bank_f_bit_oe_n = f_oe_n_ff;
  assign bank_g_bit_out = g_out_ff;
  assign bank_g_bit_oe_n = g_oe_n_ff;
  assign bank_h_bit_out = h_out_ff;
  assign bank_h_bit_oe_n = h_oe_n_ff;
  assign bank_e_pin_level = e_lvl_ff;
  assign bank_f_pin_level = f_lvl_ff;

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic ar_hs;
  logic [5:0] rd_idx;
  logic [7:0] rd_mux;
  logic rd_hit;
  assign ar_hs = ce && s_axi_arvalid && arready_ff;
  assign rd_idx = s_axi_araddr[7:2];
  assign rd_hit = (rd_idx >= `GPX_IDX_E_LATCH) && (rd_idx <= `GPX_IDX_H_DIR) && (s_axi_araddr[1:0] == 2'h0);
  assign rd_mux =
    (rd_idx == `GPX_IDX_E_LATCH) ? e_rd :
    (rd_idx == `GPX_IDX_F_LATCH) ? {2'b00, f_rd} :
    (rd_idx == `GPX_IDX_G_LATCH) ? {4'h0, g_rd} :
    (rd_idx == `GPX_IDX_H_LATCH) ? {4'h0, h_rd} :
    (rd_idx == `GPX_IDX_E_DIR) ? e_dir :
    (rd_idx == `GPX_IDX_F_DIR) ? {2'b00, f_dir} :
    (rd_idx == `GPX_IDX_G_DIR) ? {4'h0, g_dir} :
    (rd_idx == `GPX_IDX_H_DIR) ? {4'h0, h_dir} : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `GPX_RESP_OKAY;
    end else if (ce) begin
      arready_ff <= !rvalid_ff && !ar_hs;
      if (ar_hs) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= {24'h000000, rd_mux};
        rresp_ff <= rd_hit ? `GPX_RESP_OKAY : `GPX_RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_dir_reset;
    @(posedge aclk) !aresetn |=> (e_dir == `GPX_DIR_RST) && (f_dir == 6'h00) && (g_dir == 4'h0) && (h_dir == 4'h0);
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("direction not cleared by reset");
  property p_gen_drive;
    @(posedge aclk) disable iff (!aresetn) ce && !serial_interface_enable && (timer_own == 5'h00)
      |=> bank_e_bit_oe_n == ~$past(e_dir);
  endproperty
  a_gen_drive: assert property (p_gen_drive) else $error("bank E drive differs from direction");
  property p_g_read;
    @(posedge aclk) disable iff (!aresetn) ar_hs && (rd_idx == `GPX_IDX_G_LATCH)
      |=> s_axi_rvalid && (s_axi_rdata[3:0] == $past(g_rd)) && (s_axi_rdata[31:4] == 28'h0);
  endproperty
  a_g_read: assert property (p_g_read) else $error("bank G read wrong");
  property p_f_read;
    @(posedge aclk) disable iff (!aresetn) ar_hs && (rd_idx == `GPX_IDX_F_LATCH)
      |=> s_axi_rdata[5:0] == (($past(f_dir) & $past(u_bank_f.latch_ff)) | (~$past(f_dir) & $past(f_sync)));
  endproperty
  a_f_read: assert property (p_f_read) else $error("bank F read source wrong");
  property p_ss_free;
    @(posedge aclk) disable iff (!aresetn) ce && !spi_enable_bit |=> bank_f_bit_oe_n[0] == ~$past(f_dir[0]);
  endproperty
  a_ss_free: assert property (p_ss_free) else $error("slave select pin not general");
  property p_spi_drive;
    @(posedge aclk) disable iff (!aresetn) ce && spi_enable_bit
      |=> bank_f_bit_oe_n[3:1] == ~$past(spi_drive[3:1]);
  endproperty
  a_spi_drive: assert property (p_spi_drive) else $error("SPI pin drive wrong");
  property p_latch_wr;
    @(posedge aclk) disable iff (!aresetn) we_ok && (wr_idx == `GPX_IDX_H_LATCH)
      |=> u_bank_h.latch_ff == $past(wbyte[3:0]);
  endproperty
  a_latch_wr: assert property (p_latch_wr) else $error("latch write lost");
  property p_bresp;
    @(posedge aclk) disable iff (!aresetn) wr_fire
      |=> s_axi_bvalid && (s_axi_bresp == ($past(wr_hit) ? `GPX_RESP_OKAY : `GPX_RESP_SLVERR));
  endproperty
  a_bresp: assert property (p_bresp) else $error("write response wrong");
  c_wr: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready);
  c_rd: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready);
  c_spi: cover property (@(posedge aclk) disable iff (!aresetn) spi_enable_bit && !spi_master_select);
endmodule

// ===== tb/gpx_pin_partner.sv
// Pin-side partner: outside sources sharing each pin with the block
`timescale 1ns/1ps
module gpx_pin_partner (
  // Block drive
  input wire logic [21:0] drv_out,
  input wire logic [21:0] drv_oe_n,
  // Outside sources
  input wire logic [21:0] ext_level,
  output logic [21:0] pin_level
);
  // Released pins follow the outside source, never the block's last value
  assign pin_level = (drv_out & ~drv_oe_n) | (ext_level & drv_oe_n);
endmodule

// ===== tb/tb_gpio_ports_e_to_h.sv
// Self-checking bench for the bank E to H pin block
`timescale 1ns/1ps
module tb_gpio_ports_e_to_h;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [21:0] out_all, oe_all, lvl, pin_ext;
  logic [4:0] timer_own, timer_drive, timer_out;
  logic sci_en, sci_txd, spi_en, spi_mst;
  logic [3:0] spi_drive, spi_out;
  int n_mismatch, check_count, cyc, b, k;
  int off[4] = '{0, 8, 14, 18};
  logic [7:0] msk[4] = '{8'hFF, 8'h3F, 8'h0F, 8'h0F};
  logic [7:0] lat, dir, pe;
  logic [3:0] wstrb;
  logic [7:0] e_lvl;
  logic [5:0] f_lvl;

  gpx_top dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1),
    .bank_e_bit_in(lvl[7:0]), .bank_e_bit_out(out_all[7:0]), .bank_e_bit_oe_n(oe_all[7:0]),
    .bank_f_bit_in(lvl[13:8]), .bank_f_bit_out(out_all[13:8]), .bank_f_bit_oe_n(oe_all[13:8]),
    .bank_g_bit_in(lvl[17:14]), .bank_g_bit_out(out_all[17:14]), .bank_g_bit_oe_n(oe_all[17:14]),
    .bank_h_bit_in(lvl[21:18]), .bank_h_bit_out(out_all[21:18]), .bank_h_bit_oe_n(oe_all[21:18]),
    .timer_own(timer_own), .timer_drive(timer_drive), .timer_out(timer_out),
    .serial_interface_enable(sci_en), .sci_txd(sci_txd),
    .spi_enable_bit(spi_en), .spi_master_select(spi_mst), .spi_drive(spi_drive), .spi_out(spi_out),
    .bank_e_pin_level(e_lvl), .bank_f_pin_level(f_lvl));

  gpx_pin_partner pins (.drv_out(out_all), .drv_oe_n(oe_all), .ext_level(pin_ext), .pin_level(lvl));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ****************
  // Shared tasks
  // ****************
  function automatic logic [7:0] slc(input logic [21:0] v, input int i);
    return 8'((v >> off[i]) & 22'(msk[i]));
  endfunction

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Bus waits end on the response; a hung wait ends only through the global cycle limit
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic awp, wp;
    awp = 1'b1;
    wp = 1'b1;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awp && s_axi_awready) begin
        awp = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (wp && s_axi_wready) begin
        wp = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) begin
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid) begin
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
        chk("rdata", s_axi_rdata, exp);
        break;
      end
    end
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Well above the few hundred cycles the sequence needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  // ****************
  // Test sequence
  // ****************
  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_wdata = 32'h0;
    wstrb = 4'h1;
    pin_ext = 22'h2A5C39;
    {timer_own, timer_drive, timer_out} = 15'h0;
    {sci_en, sci_txd, spi_en, spi_mst} = 4'h0;
    spi_drive = 4'h0;
    spi_out = 4'h0;
    do_reset();
    for (b = 0; b < 4; b++) begin
      rd(8'(8'h30 + 4 * b), 32'h0, 2'h0);
    end
    chk("oe_n", oe_all, 22'h3FFFFF);
    $display("test reset done");
    for (b = 0; b < 4; b++) begin
      for (k = 0; k < 2; k++) begin
        lat = (k == 1 ? 8'h3C : 8'hC3) & msk[b];
        dir = (k == 1 ? 8'hF0 : 8'h0F) & msk[b];
        pe = slc(pin_ext, b);
        wr(8'(8'h20 + 4 * b), 32'(lat), 2'h0);
        wr(8'(8'h30 + 4 * b), 32'(dir), 2'h0);
        repeat (4) @(posedge aclk);
        rd(8'(8'h20 + 4 * b), 32'((lat & dir) | (pe & ~dir)), 2'h0);
        if (b < 2) begin
          chk("pin_level", b == 0 ? e_lvl : {2'b00, f_lvl}, 32'((lat & dir) | (pe & ~dir)));
        end
        chk("oe_n", slc(oe_all, b), ~dir & msk[b]);
        chk("out", slc(out_all, b) & dir, lat & dir);
        wr(8'(8'h20 + 4 * b), 32'(~lat & msk[b]), 2'h0);
        repeat (4) @(posedge aclk);
        rd(8'(8'h20 + 4 * b), 32'((~lat & dir) | (pe & ~dir)), 2'h0);
      end
    end
    $display("test banks done");
    wr(8'h34, 32'hFF, 2'h0);
    rd(8'h34, 32'h3F, 2'h0);
    wr(8'h2C, 32'hFF, 2'h0);
    wr(8'h3C, 32'hFF, 2'h0);
    rd(8'h2C, 32'h0F, 2'h0);
    // Lane 0 strobe low: accepted, but the latch must keep its value
    wstrb <= 4'h0;
    wr(8'h2C, 32'h00, 2'h0);
    wstrb <= 4'h1;
    rd(8'h2C, 32'h0F, 2'h0);
    wr(8'h40, 32'hFF, 2'h2);
    rd(8'h40, 32'h0, 2'h2);
    $display("test decode done");
    wr(8'h24, 32'h2D, 2'h0);
    wr(8'h28, 32'h09, 2'h0);
    wr(8'h2C, 32'h06, 2'h0);
    do_reset();
    rd(8'h34, 32'h0, 2'h0);
    rd(8'h3C, 32'h0, 2'h0);
    for (b = 1; b < 4; b++) begin
      wr(8'(8'h30 + 4 * b), 32'hFF, 2'h0);
    end
    rd(8'h24, 32'h2D, 2'h0);
    rd(8'h28, 32'h09, 2'h0);
    rd(8'h2C, 32'h06, 2'h0);
    $display("test latch keep done");
    wr(8'h24, 32'h15, 2'h0);
    spi_en <= 1'b1;
    spi_drive <= 4'b0111;
    spi_out <= 4'b0100;
    repeat (4) @(posedge aclk);
    chk("f_oe_n", slc(oe_all, 1), 8'h09);
    chk("f_out", slc(out_all, 1) & 8'h06, 8'h04);
    rd(8'h24, 32'h15, 2'h0);
    spi_mst <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("f0_oe_n", slc(oe_all, 1) & 8'h01, 8'h01);
    spi_en <= 1'b0;
    repeat (4) @(posedge aclk);
    chk("f_oe_n", slc(oe_all, 1), 8'h00);
    $display("test spi done");
    wr(8'h20, 32'h00, 2'h0);
    wr(8'h30, 32'hFF, 2'h0);
    sci_en <= 1'b1;
    sci_txd <= 1'b1;
    timer_own <= 5'b00101;
    timer_drive <= 5'b00001;
    timer_out <= 5'b00001;
    repeat (4) @(posedge aclk);
    chk("e_oe_n", slc(oe_all, 0), 8'h22);
    chk("e_out", slc(out_all, 0) & 8'hDD, 8'h0C);
    rd(8'h20, 32'h00, 2'h0);
    sci_en <= 1'b0;
    timer_own <= 5'b00000;
    repeat (4) @(posedge aclk);
    chk("e_oe_n", slc(oe_all, 0), 8'h00);
    $display("test shared e done");
    wrap_up();
  end
endmodule
